// ### logic/gdfp_core.sv
// Protection and supervision logic of an integrated power-switch gate driver.
`timescale 1ns/1ps

module gdfp_core #(
	parameter int unsigned sc_reset_cycles = gdfp_pkg::sc_reset_cyc
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic switch_cmd,
	input wire logic oc_detect,
	input wire logic sc_detect,
	input wire logic fet_hot,
	input wire logic driver_hot,
	input wire logic supply_ok,
	input wire logic drive_res_open,
	input wire logic oc_pin_grounded,
	output logic gate_on,
	output logic slow_turnoff,
	output logic diode_mode,
	output logic aux_regulator_rail,
	output logic negative_gate_rail,
	output logic converter_high_limit,
	output logic fault_n,
	output logic overcurrent_flag_n
);

	// ****************************************************************
	// State
	// ****************************************************************

	// Present and next block state.
	gdfp_pkg::gdfp_state_t s_reg;
	gdfp_pkg::gdfp_state_t s_next;

	// Saturation limit of timers.
	localparam logic [gdfp_pkg::cnt_w-1:0] cnt_max = '1;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************

	// One process computes the whole next state from inputs and state.
	always_comb begin
		logic rise;
		logic fall;
		logic oc_delayed;
		logic sc_now;
		logic any_fault;
		rise = 1'b0;
		fall = 1'b0;
		oc_delayed = 1'b0;
		sc_now = 1'b0;
		any_fault = 1'b0;
		s_next = s_reg;
		s_next.cmd_d = switch_cmd;
		rise = switch_cmd && !s_reg.cmd_d;
		fall = !switch_cmd && s_reg.cmd_d;

		// The strap is caught one clock after reset release.
		if (!s_reg.strap_done) begin
			s_next.strap_done = 1'b1;
			s_next.combined = oc_pin_grounded;
		end

		// Period measure between command rising edges.
		if (s_reg.per_cnt != cnt_max) begin
			s_next.per_cnt = s_reg.per_cnt + 1'b1;
		end
		if (rise) begin
			s_next.per_cnt = '0;
			if (!s_reg.high_limit) begin
				// A short period counts; a long one restarts the filter.
				if (s_reg.per_cnt <
					gdfp_pkg::cnt_w'(gdfp_pkg::freq_period_cyc)) begin
					s_next.fast_cnt = s_reg.fast_cnt + 3'h1;
				end else begin
					s_next.fast_cnt = 3'h0;
				end
			end
		end
		// Once taken, the high limit never returns low until reset.
		if (s_next.fast_cnt == 3'(gdfp_pkg::fast_cycles_needed)) begin
			s_next.high_limit = 1'b1;
		end

		// Overcurrent timer runs while the comparator is tripped.
		if (oc_detect) begin
			if (s_reg.oc_cnt != cnt_max) begin
				s_next.oc_cnt = s_reg.oc_cnt + 1'b1;
			end
		end else begin
			s_next.oc_cnt = '0;
		end
		// Window timer delays the overcurrent signal for classification.
		if (oc_detect) begin
			if (s_reg.win_cnt != cnt_max) begin
				s_next.win_cnt = s_reg.win_cnt + 1'b1;
			end
		end else begin
			s_next.win_cnt = '0;
		end
		oc_delayed = s_reg.win_cnt >=
			gdfp_pkg::cnt_w'(gdfp_pkg::oc_window_cyc);
		// Short wins only if seen before the delayed overcurrent.
		sc_now = sc_detect && !oc_delayed && !s_reg.oc_trip;
		if (sc_now) begin
			s_next.sc_latch = 1'b1;
		end
		// Overcurrent clears on the command going low.
		if (!switch_cmd) begin
			s_next.oc_trip = 1'b0;
		end
		// A trip in the same cycle as the clear wins, so no event is lost.
		if (!s_reg.sc_latch && s_reg.gate_on && oc_delayed &&
			s_reg.oc_cnt >= gdfp_pkg::cnt_w'(gdfp_pkg::oc_delay_cyc)) begin
			s_next.oc_trip = 1'b1;
		end

		// Short latch clears after a long enough low command.
		if (switch_cmd) begin
			s_next.low_cnt = '0;
		end else if (s_reg.low_cnt != cnt_max) begin
			s_next.low_cnt = s_reg.low_cnt + 1'b1;
		end
		// The latch drops only while the command is still low, so a
		// rising command never sees it fall in the same cycle.
		if (s_reg.sc_latch && !sc_now && !switch_cmd &&
			s_next.low_cnt >= gdfp_pkg::cnt_w'(sc_reset_cycles)) begin
			s_next.sc_latch = 1'b0;
		end

		// Thermal supervision; driver trip dominates transistor trip.
		case (s_reg.th)
			gdfp_pkg::gdfp_th_normal: begin
				if (driver_hot) begin
					s_next.th = gdfp_pkg::gdfp_th_shut;
				end else if (fet_hot) begin
					s_next.th = gdfp_pkg::gdfp_th_diode;
				end
			end
			gdfp_pkg::gdfp_th_diode: begin
				if (driver_hot) begin
					s_next.th = gdfp_pkg::gdfp_th_shut;
				end else if (!fet_hot) begin
					s_next.th = gdfp_pkg::gdfp_th_normal;
				end
			end
			gdfp_pkg::gdfp_th_shut: begin
				if (!driver_hot && fet_hot) begin
					s_next.th = gdfp_pkg::gdfp_th_diode;
				end else if (!driver_hot && !fet_hot) begin
					s_next.th = gdfp_pkg::gdfp_th_normal;
				end
			end
			default: begin
				s_next.th = gdfp_pkg::gdfp_th_shut;
			end
		endcase

		// Registered outputs, computed from the next state.
		s_next.diode_mode = s_next.th == gdfp_pkg::gdfp_th_diode;
		s_next.aux_en = s_next.th != gdfp_pkg::gdfp_th_shut;
		s_next.rail_en = s_next.th != gdfp_pkg::gdfp_th_shut;
		s_next.high_limit_o = s_next.high_limit;
		// The gate follows the command only with no fault holding it off.
		s_next.gate_on = switch_cmd && supply_ok && !s_next.oc_trip &&
			!s_next.sc_latch &&
			s_next.th == gdfp_pkg::gdfp_th_normal;
		s_next.slow_off = s_next.sc_latch;
		any_fault = !supply_ok || drive_res_open ||
			s_next.th != gdfp_pkg::gdfp_th_normal;
		// Output encoding; combined mode puts everything on fault.
		if (s_next.combined) begin
			s_next.fault_n = !(any_fault || s_next.sc_latch ||
				s_next.oc_trip);
			s_next.oc_flag_n = 1'b1;
		end else begin
			s_next.fault_n = !(any_fault || s_next.sc_latch);
			s_next.oc_flag_n = !(s_next.oc_trip || s_next.sc_latch);
		end
	end

	// ****************************************************************
	// Register
	// ****************************************************************

	// Reset holds the switch off and fault low until the first clock.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '{th: gdfp_pkg::gdfp_th_normal, aux_en: 1'b0,
				oc_flag_n: 1'b1, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign gate_on = s_reg.gate_on;
	assign slow_turnoff = s_reg.slow_off;
	assign diode_mode = s_reg.diode_mode;
	assign aux_regulator_rail = s_reg.aux_en;
	assign negative_gate_rail = s_reg.rail_en;
	assign converter_high_limit = s_reg.high_limit_o;
	assign fault_n = s_reg.fault_n;
	assign overcurrent_flag_n = s_reg.oc_flag_n;

endmodule // gdfp_core

// ### pkg/gdfp_pkg.sv
// Constants and types for the gate-driver protection and supervision block.
package gdfp_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************

	// Clock period in picoseconds.
	localparam int unsigned clk_period_ps = 4000;
	// Overcurrent detection delay, nanoseconds.
	localparam int unsigned oc_delay_ns = 100;
	localparam int unsigned oc_delay_cyc = (oc_delay_ns * 1000) / clk_period_ps;
	// Overcurrent window used to tell slow from fast current rise, ns.
	localparam int unsigned oc_window_ns = 40;
	localparam int unsigned oc_window_cyc =
		(oc_window_ns * 1000) / clk_period_ps;
	// Minimum command low time that resets the short latch, ns.
	localparam int unsigned sc_reset_ns = 250000;
	localparam int unsigned sc_reset_cyc =
		(sc_reset_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
	// Frequency threshold period (command rise to rise), ns.
	localparam int unsigned freq_period_ns = 1000;
	localparam int unsigned freq_period_cyc =
		(freq_period_ns * 1000) / clk_period_ps;
	// Consecutive fast cycles needed before the high limit is taken.
	localparam int unsigned fast_cycles_needed = 5;

	// Counter width shared by all timers.
	localparam int unsigned cnt_w = 20;

	// ****************************************************************
	// Types
	// ****************************************************************

	// Thermal supervision states, one-hot.
	typedef enum logic [2:0] {
		gdfp_th_normal = 3'h1,
		gdfp_th_diode = 3'h2,
		gdfp_th_shut = 3'h4
	} gdfp_th_t;

	// Whole state of the block, registered as one word.
	typedef struct packed {
		logic cmd_d;
		logic [cnt_w-1:0] per_cnt;
		logic [2:0] fast_cnt;
		logic high_limit;
		logic [cnt_w-1:0] oc_cnt;
		logic [cnt_w-1:0] win_cnt;
		logic oc_trip;
		logic sc_latch;
		logic [cnt_w-1:0] low_cnt;
		gdfp_th_t th;
		logic strap_done;
		logic combined;
		logic gate_on;
		logic slow_off;
		logic diode_mode;
		logic aux_en;
		logic rail_en;
		logic high_limit_o;
		logic fault_n;
		logic oc_flag_n;
	} gdfp_state_t;

endpackage

// ### test/gdfp_ctrl_model.sv
// PWM controller model driving the switch command.
`timescale 1ns/1ps
module gdfp_ctrl_model (
	input wire logic clock,
	output logic switch_cmd
);
	// Low is the safe idle level of the command.
	initial switch_cmd = 1'b0;
	// Hold the command for n cycles; called just after a falling edge.
	task automatic hold(input logic v, input int n);
		switch_cmd = v;
		repeat (n) @(negedge clock);
	endtask
	// Pulses of 20 high cycles at the given rise-to-rise period.
	task automatic pulses(input int period, input int n);
		repeat (n) begin
			hold(1'b1, 20);
			hold(1'b0, period - 20);
		end
	endtask
endmodule // gdfp_ctrl_model

// ### test/gdfp_core_properties.sv
// Concurrent checks on the ports of the protection block.
`timescale 1ns/1ps
module gdfp_core_properties (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic switch_cmd,
	input wire logic oc_detect,
	input wire logic sc_detect,
	input wire logic fet_hot,
	input wire logic driver_hot,
	input wire logic supply_ok,
	input wire logic drive_res_open,
	input wire logic oc_pin_grounded,
	input wire logic gate_on,
	input wire logic slow_turnoff,
	input wire logic diode_mode,
	input wire logic aux_regulator_rail,
	input wire logic negative_gate_rail,
	input wire logic converter_high_limit,
	input wire logic fault_n,
	input wire logic overcurrent_flag_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// The flag may take up to two edges to come back.
	sequence s_flag_back;
		##[1:2] overcurrent_flag_n;
	endsequence
	a_undervolt_off: assert property (
		!supply_ok |=> !fault_n && !gate_on) else $error("undervolt");
	a_hot_fault: assert property (
		fet_hot || driver_hot |=> !fault_n) else $error("hot fault");
	a_driver_shut: assert property (
		driver_hot |=> !aux_regulator_rail && !negative_gate_rail
		&& !gate_on && !diode_mode) else $error("driver hot");
	a_fet_diode: assert property (
		fet_hot && !driver_hot |=> diode_mode) else $error("diode");
	a_limit_sticky: assert property (
		converter_high_limit |=> converter_high_limit) else $error("limit");
	a_short_off: assert property (
		slow_turnoff |-> !gate_on && !fault_n) else $error("short off");
	a_short_hold: assert property (
		slow_turnoff && switch_cmd |=> slow_turnoff) else $error("latch");
	a_flag_clear: assert property (
		!overcurrent_flag_n && !slow_turnoff && !switch_cmd |-> s_flag_back)
		else $error("flag clear");
	a_oc_delay: assert property (
		$fell(overcurrent_flag_n) && !slow_turnoff |-> $past(oc_detect, 24))
		else $error("oc early");
endmodule // gdfp_core_properties
bind gdfp_core gdfp_core_properties u_props (
	.clock(clock),
	.rst_n(rst_n),
	.switch_cmd(switch_cmd),
	.oc_detect(oc_detect),
	.sc_detect(sc_detect),
	.fet_hot(fet_hot),
	.driver_hot(driver_hot),
	.supply_ok(supply_ok),
	.drive_res_open(drive_res_open),
	.oc_pin_grounded(oc_pin_grounded),
	.gate_on(gate_on),
	.slow_turnoff(slow_turnoff),
	.diode_mode(diode_mode),
	.aux_regulator_rail(aux_regulator_rail),
	.negative_gate_rail(negative_gate_rail),
	.converter_high_limit(converter_high_limit),
	.fault_n(fault_n),
	.overcurrent_flag_n(overcurrent_flag_n)
);

// ### test/gan_driver_fault_protection_tb_top.sv
// Self-checking bench for the gate-driver protection block.
`timescale 1ns/1ps
module gan_driver_fault_protection_tb_top;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic switch_cmd, gate_on, slow_turnoff, diode_mode;
	logic oc_detect = 1'b0, sc_detect = 1'b0, fet_hot = 1'b0;
	logic driver_hot = 1'b0, supply_ok = 1'b1, drive_res_open = 1'b0;
	logic oc_pin_grounded = 1'b0, aux_regulator_rail, negative_gate_rail;
	logic converter_high_limit, fault_n, overcurrent_flag_n;
	int n_mismatch = 0;
	int compares = 0;
	always #2 clock = ~clock;
	// Short latch release shortened so the long-low test stays brief.
	gdfp_core #(.sc_reset_cycles(20)) dut (
		.clock(clock),
		.rst_n(rst_n),
		.switch_cmd(switch_cmd),
		.oc_detect(oc_detect),
		.sc_detect(sc_detect),
		.fet_hot(fet_hot),
		.driver_hot(driver_hot),
		.supply_ok(supply_ok),
		.drive_res_open(drive_res_open),
		.oc_pin_grounded(oc_pin_grounded),
		.gate_on(gate_on),
		.slow_turnoff(slow_turnoff),
		.diode_mode(diode_mode),
		.aux_regulator_rail(aux_regulator_rail),
		.negative_gate_rail(negative_gate_rail),
		.converter_high_limit(converter_high_limit),
		.fault_n(fault_n),
		.overcurrent_flag_n(overcurrent_flag_n)
	);
	gdfp_ctrl_model u_ctrl (.clock(clock), .switch_cmd(switch_cmd));
	task automatic chk(input string what, input logic seen, input logic exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic complete_run();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic t_freq();
		chk("limit0", converter_high_limit, 1'b0);
		u_ctrl.pulses(100, 4);
		u_ctrl.pulses(300, 2);
		u_ctrl.pulses(100, 5);
		chk("limit4", converter_high_limit, 1'b0);
		u_ctrl.pulses(100, 1);
		chk("limit5", converter_high_limit, 1'b1);
		u_ctrl.pulses(300, 3);
		chk("limitkeep", converter_high_limit, 1'b1);
	endtask
	task automatic t_oc();
		int n = 0;
		u_ctrl.hold(1'b1, 2);
		oc_detect = 1'b1;
		while (overcurrent_flag_n !== 1'b0 && n < 60) begin
			// A short sample after the window must still read as overcurrent.
			if (n == 15) begin
				sc_detect = 1'b1;
			end
			tick(1);
			n++;
		end
		// Trip after the full delay, shown one registered cycle later.
		chk("ocdelay", n == gdfp_pkg::oc_delay_cyc + 1, 1'b1);
		chk("occlass", slow_turnoff, 1'b0);
		chk("ocgate", gate_on, 1'b0);
		chk("ocfault", fault_n, 1'b1);
		oc_detect = 1'b0;
		sc_detect = 1'b0;
		u_ctrl.hold(1'b0, 3);
		chk("occlear", overcurrent_flag_n, 1'b1);
		u_ctrl.hold(1'b1, 2);
		chk("ocnext", gate_on, 1'b1);
		u_ctrl.hold(1'b0, 2);
	endtask
	task automatic t_short();
		u_ctrl.hold(1'b1, 2);
		oc_detect = 1'b1;
		sc_detect = 1'b1;
		tick(3);
		oc_detect = 1'b0;
		sc_detect = 1'b0;
		chk("scslow", slow_turnoff, 1'b1);
		chk("scfault", fault_n, 1'b0);
		chk("scflag", overcurrent_flag_n, 1'b0);
		u_ctrl.hold(1'b0, 10);
		u_ctrl.hold(1'b1, 3);
		chk("scheld", gate_on, 1'b0);
		u_ctrl.hold(1'b0, 25);
		u_ctrl.hold(1'b1, 3);
		chk("scgone", slow_turnoff, 1'b0);
		chk("scresume", gate_on, 1'b1);
		u_ctrl.hold(1'b0, 2);
	endtask
	task automatic t_thermal();
		fet_hot = 1'b1;
		tick(3);
		chk("diode", diode_mode, 1'b1);
		chk("thfault", fault_n, 1'b0);
		driver_hot = 1'b1;
		tick(3);
		chk("aux", aux_regulator_rail, 1'b0);
		chk("rail", negative_gate_rail, 1'b0);
		chk("nodiode", diode_mode, 1'b0);
		driver_hot = 1'b0;
		tick(3);
		chk("rediode", diode_mode, 1'b1);
		fet_hot = 1'b0;
		tick(3);
		chk("cool", fault_n, 1'b1);
		chk("auxon", aux_regulator_rail, 1'b1);
	endtask
	task automatic t_uv();
		u_ctrl.hold(1'b1, 2);
		supply_ok = 1'b0;
		tick(3);
		chk("uvgate", gate_on, 1'b0);
		chk("uvfault", fault_n, 1'b0);
		chk("uvflag", overcurrent_flag_n, 1'b1);
		supply_ok = 1'b1;
		tick(3);
		chk("uvback", gate_on, 1'b1);
		u_ctrl.hold(1'b0, 2);
		drive_res_open = 1'b1;
		tick(3);
		chk("resopen", fault_n, 1'b0);
		drive_res_open = 1'b0;
		tick(3);
	endtask
	task automatic t_strap();
		oc_pin_grounded = 1'b1;
		rst_n = 1'b0;
		tick(4);
		rst_n = 1'b1;
		tick(3);
		u_ctrl.hold(1'b1, 2);
		oc_detect = 1'b1;
		tick(40);
		chk("strapflag", overcurrent_flag_n, 1'b1);
		chk("strapfault", fault_n, 1'b0);
		oc_detect = 1'b0;
		u_ctrl.hold(1'b0, 3);
	endtask
	initial begin
		tick(4);
		rst_n = 1'b1;
		tick(2);
		u_ctrl.hold(1'b0, 260);
		t_freq();
		t_oc();
		t_short();
		t_thermal();
		t_uv();
		t_strap();
		complete_run();
	end
	// Whole run is near 3000 cycles; a hang is cut off well past that.
	initial begin
		tick(20000);
		n_mismatch++;
		complete_run();
	end
endmodule // gan_driver_fault_protection_tb_top
